// ===== common/mbd_pkg.sv
// package: address map constants and carrier types of the memory map decoder
package mbd_pkg;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h007F;
  localparam logic [15:0] GAP_LO = 16'h0080;
  localparam logic [15:0] GAP_HI = 16'h008F;
  localparam logic [15:0] RAM_LO = 16'h0090;
  localparam logic [15:0] DIR_HI = 16'h00FF;
  localparam logic [15:0] GPR_LO = 16'h0100;
  localparam logic [15:0] GPR_HI = 16'h01FF;
  localparam logic [15:0] XIO_LO = 16'h0F80;
  localparam logic [15:0] XIO_HI = 16'h0FFF;
  localparam logic [15:0] NVW_LO = 16'hFFBB;
  localparam logic [15:0] NVW_HI = 16'hFFBF;
  localparam logic [15:0] VEC_LO = 16'hFFC0;
  localparam logic [15:0] VEC_HI = 16'hFFFF;
  localparam logic [15:0] FLASH_BASE_DEF = 16'hF000;

  // banked window: phys = {bank, op[6:0]} + offset
  localparam logic [15:0] BANK_OFS = 16'h0080;

  // ----------------------------------------
  // ram variants
  // ----------------------------------------
  localparam logic [1:0] VAR_256 = 2'h0;
  localparam logic [1:0] VAR_512 = 2'h1;
  localparam logic [1:0] VAR_1K = 2'h2;
  localparam logic [15:0] RAM_HI_256 = 16'h018F;
  localparam logic [15:0] RAM_HI_512 = 16'h028F;
  localparam logic [15:0] RAM_HI_1K = 16'h048F;
  localparam int RAM_AW = 10;
  localparam int RAM_DEPTH = 1024;

  // ----------------------------------------
  // reset and idle values
  // ----------------------------------------
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic direct;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mbd_req_t;

  typedef struct packed {
    logic io;
    logic ext_io;
    logic ram;
    logic gpr;
    logic flash;
    logic nvw;
    logic vector;
    logic prohib;
  } mbd_sel_t;

endpackage

// ===== verilog/mbd_ram.sv
// module: data-area static ram with a registered read port
`timescale 1ns/1ps
module mbd_ram (
  input wire logic clk_i,                               // machine clock
  input wire logic we_i,                                // write strobe
  input wire logic re_i,                                // read strobe
  input wire logic [mbd_pkg::RAM_AW-1:0] idx_i,         // word index
  input wire logic [7:0] wdata_i,                       // write data
  output logic [7:0] rdata_o                            // registered read data
);

  logic [7:0] mem [mbd_pkg::RAM_DEPTH];

  // no reset on the array; read data idles at a fixed value when not reading
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[idx_i] <= wdata_i;
    end
    if (re_i)
    begin
      rdata_o <= mem[idx_i];
    end
    else
    begin
      rdata_o <= mbd_pkg::RDATA_IDLE;
    end
  end

endmodule

// ===== verilog/mbd_dir_xlate.sv
// module: direct-operand translation through the bank pointer
`timescale 1ns/1ps
module mbd_dir_xlate (
  input wire logic [2:0] bank_i,                        // direct bank pointer
  input wire logic [7:0] op_i,                          // direct operand
  output logic [15:0] phys_o                            // physical address
);

  always_comb
  begin
    if (!op_i[7] || bank_i == mbd_pkg::BANK_RST)
    begin
      phys_o = {8'h00, op_i};
    end
    else
    begin
      // 128-byte windows from 0x0100 upward
      phys_o = 16'({6'h00, bank_i, op_i[6:0]} + mbd_pkg::BANK_OFS);
    end
  end

endmodule

// ===== verilog/mbd_decoder.sv
// module: 64 KB memory map decoder with direct bank pointer
//
// Notes on behaviour
// - one 16-bit map, four areas
// - 0x0000-0x007F is I/O, direct too
// - 0x0F80-0x0FFF extended I/O, not direct
// - direct 0x0090-0x00FF reaches RAM unbanked at bank 0
// - banked direct RAM top depends on variant
// - general registers 0x0100-0x01FF, small 0x018F
// - general registers remain ordinary RAM
// - 0xFFC0-0xFFFF is the vector table
// - 0xFFBB-0xFFBF holds nonvolatile setting word
// - flash ends at top, holds vectors
// - direct 0x00-0x7F ignores bank pointer
// - bank pointer resets zero, maps windows
// - banked access limited to present RAM
// - RAM size 256/512/1024 by variant
// - 0x0080-0x008F is prohibited
`timescale 1ns/1ps
module mbd_decoder #(
  parameter logic [15:0] FLASH_BASE = mbd_pkg::FLASH_BASE_DEF
) (
  input wire logic ref_clk_i,                           // 10 MHz machine clock
  input wire logic rst_b_i,                             // async reset, active low
  input wire logic [1:0] variant_i,                     // ram size strap pin
  input wire mbd_pkg::mbd_req_t req_i,                  // cpu access request
  input wire logic bank_wr_i,                           // bank pointer load
  input wire logic [2:0] bank_wdata_i,                  // new bank pointer
  output logic rsp_valid_o,                             // decode result valid
  output mbd_pkg::mbd_sel_t sel_o,                      // area selects
  output logic [15:0] phys_addr_o,                      // translated address
  output logic [7:0] rdata_o,                           // ram read data
  output logic [2:0] bank_ptr_o                         // direct bank pointer
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_b;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_sync_r <= 2'h0;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_r[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] var_s1;
    logic [1:0] var_s2;
    logic [2:0] bank;
    logic rsp_valid;
    mbd_pkg::mbd_sel_t sel;
    logic [15:0] phys;
  } mbd_state_t;

  mbd_state_t st_r;
  mbd_state_t st_nxt;

  // ----------------------------------------
  // area decode
  // ----------------------------------------
  function automatic logic [15:0] ram_top(input logic [1:0] v);
    case (v)
      mbd_pkg::VAR_256: ram_top = mbd_pkg::RAM_HI_256;
      mbd_pkg::VAR_512: ram_top = mbd_pkg::RAM_HI_512;
      default: ram_top = mbd_pkg::RAM_HI_1K;
    endcase
  endfunction

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic mbd_pkg::mbd_sel_t decode(input logic [15:0] a, input logic [1:0] v,
                                              input logic direct, input logic [15:0] fbase);
    mbd_pkg::mbd_sel_t s;
    s = '0;
    s.io = in_rng(a, mbd_pkg::IO_LO, mbd_pkg::IO_HI);
    s.ext_io = !direct && in_rng(a, mbd_pkg::XIO_LO, mbd_pkg::XIO_HI);
    s.ram = in_rng(a, mbd_pkg::RAM_LO, ram_top(v));
    s.gpr = s.ram && in_rng(a, mbd_pkg::GPR_LO, mbd_pkg::GPR_HI);
    s.flash = !direct && (a >= fbase);
    s.nvw = s.flash && in_rng(a, mbd_pkg::NVW_LO, mbd_pkg::NVW_HI);
    s.vector = s.flash && in_rng(a, mbd_pkg::VEC_LO, mbd_pkg::VEC_HI);
    // the gap, space above ram and unused space all fall through here
    s.prohib = !(s.io || s.ext_io || s.ram || s.flash);
    return s;
  endfunction

  // ----------------------------------------
  // direct operand translation
  // ----------------------------------------
  logic [15:0] dir_phys;
  logic [15:0] acc_addr;
  mbd_pkg::mbd_sel_t acc_sel;

  mbd_dir_xlate u_xlate (
    .bank_i (st_r.bank),
    .op_i (req_i.addr[7:0]),
    .phys_o (dir_phys)
  );

  assign acc_addr = req_i.direct ? dir_phys : req_i.addr;
  assign acc_sel = decode(acc_addr, st_r.var_s2, req_i.direct, FLASH_BASE);

  // ----------------------------------------
  // ram
  // ----------------------------------------
  logic ram_we;
  logic ram_re;
  logic [mbd_pkg::RAM_AW-1:0] ram_idx;

  // only a decoded ram hit touches storage; everything else is dropped
  assign ram_we = req_i.valid && req_i.write && acc_sel.ram;
  assign ram_re = req_i.valid && !req_i.write && acc_sel.ram;
  assign ram_idx = mbd_pkg::RAM_AW'(acc_addr - mbd_pkg::RAM_LO);

  mbd_ram u_ram (
    .clk_i (ref_clk_i),
    .we_i (ram_we),
    .re_i (ram_re),
    .idx_i (ram_idx),
    .wdata_i (req_i.wdata),
    .rdata_o (rdata_o)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // strap pin from outside the clock domain
    st_nxt.var_s1 = variant_i;
    st_nxt.var_s2 = st_r.var_s1;
    if (bank_wr_i)
    begin
      st_nxt.bank = bank_wdata_i;
    end
    st_nxt.rsp_valid = req_i.valid;
    if (req_i.valid)
    begin
      st_nxt.sel = acc_sel;
      st_nxt.phys = acc_addr;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '{var_s1: mbd_pkg::VAR_1K, var_s2: mbd_pkg::VAR_1K, bank: mbd_pkg::BANK_RST,
                rsp_valid: 1'b0, sel: '0, phys: 16'h0000};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid_o = st_r.rsp_valid;
  assign sel_o = st_r.sel;
  assign phys_addr_o = st_r.phys;
  assign bank_ptr_o = st_r.bank;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b);

  io_select_a: assert property (req_i.valid && req_i.addr <= 16'h007F |=> sel_o.io && !sel_o.prohib)
    else $error("i/o address not decoded as i/o");

  ext_io_direct_a: assert property (req_i.valid && req_i.direct |=> !sel_o.ext_io && !sel_o.flash)
    else $error("direct operand reached extended i/o or flash");

  ext_io_mem_a: assert property (req_i.valid && !req_i.direct && req_i.addr >= 16'h0F80
                                 && req_i.addr <= 16'h0FFF |=> sel_o.ext_io)
    else $error("extended i/o address missed");

  low_direct_a: assert property (req_i.valid && req_i.direct && !req_i.addr[7]
                                 |=> phys_addr_o == {8'h00, $past(req_i.addr[7:0])} && sel_o.io)
    else $error("low direct operand translated");

  bank_zero_a: assert property (req_i.valid && req_i.direct && bank_ptr_o == 3'h0
                                |=> phys_addr_o == {8'h00, $past(req_i.addr[7:0])})
    else $error("bank zero did not map unchanged");

  bank_window_a: assert property (req_i.valid && req_i.direct && req_i.addr[7] && bank_ptr_o != 3'h0
                                  |=> phys_addr_o == 16'h0080 + 16'($past(bank_ptr_o)) * 16'h0080
                                      + 16'($past(req_i.addr[6:0])))
    else $error("banked window address wrong");

  gap_prohib_a: assert property (req_i.valid && !req_i.direct && req_i.addr >= 16'h0080
                                 && req_i.addr <= 16'h008F |=> sel_o.prohib && !sel_o.ram)
    else $error("gap not prohibited");

  small_ram_top_a: assert property (req_i.valid && st_r.var_s2 == 2'h0 && !req_i.direct
                                    && req_i.addr == 16'h0190 |=> sel_o.prohib && !sel_o.gpr)
    else $error("small variant ram runs past 0x018F");

  gpr_a: assert property (req_i.valid && !req_i.direct && req_i.addr >= 16'h0100
                          && req_i.addr <= 16'h018F |=> sel_o.gpr && sel_o.ram)
    else $error("general register area missed");

  vector_a: assert property (req_i.valid && !req_i.direct && req_i.addr >= 16'hFFC0
                             |=> sel_o.vector && sel_o.flash && !sel_o.nvw)
    else $error("vector table not decoded in flash");

  nv_word_a: assert property (req_i.valid && !req_i.direct && req_i.addr >= 16'hFFBB
                              && req_i.addr <= 16'hFFBF |=> sel_o.nvw && !sel_o.vector)
    else $error("nonvolatile setting word area missed");

  prohib_read_a: assert property (req_i.valid && !req_i.write && !acc_sel.ram |=> rdata_o == 8'h00)
    else $error("non-ram read returned ram data");

  ram_echo_a: assert property (req_i.valid && req_i.write && acc_sel.ram ##1
                               req_i.valid && !req_i.write && acc_sel.ram
                               && $past(acc_addr) == acc_addr |=> rdata_o == $past(req_i.wdata, 2))
    else $error("ram did not return written byte");

  bank_cov: cover property (req_i.valid && req_i.direct && req_i.addr[7] && bank_ptr_o == 3'h7);
  gpr_cov: cover property (req_i.valid && req_i.write && acc_sel.gpr);
  prohib_cov: cover property (req_i.valid && req_i.write && acc_sel.prohib);
  vector_cov: cover property (req_i.valid && acc_sel.vector);

endmodule

// ===== testbench/mbd_cpu_model.sv
// cpu core model: issues byte requests and direct bank pointer loads
`timescale 1ns/1ps
module mbd_cpu_model (
  input wire logic clk_i,                  // machine clock
  output mbd_pkg::mbd_req_t req_o,         // access request
  output logic bank_wr_o,                  // bank pointer load
  output logic [2:0] bank_wdata_o          // new bank pointer
);
  // ------------
  // bus cycles, each entered and left at a falling edge
  // ------------
  initial
  begin
    req_o = '0;
    bank_wr_o = 1'h0;
    bank_wdata_o = 3'h0;
  end

  // valid stays up on return so requests can run back to back
  task automatic issue(input logic dir, input logic wr, input logic [15:0] addr, input logic [7:0] wd);
    req_o = '{valid: 1'h1, write: wr, direct: dir, addr: addr, wdata: wd};
    bank_wr_o = 1'h0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // released lines flip, so a stale value never decodes by luck
  task automatic idle();
    req_o = '{valid: 1'h0, write: ~req_o.write, direct: ~req_o.direct, addr: ~req_o.addr, wdata: ~req_o.wdata};
    bank_wr_o = 1'h0;
    bank_wdata_o = ~bank_wdata_o;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic load_bank(input logic [2:0] b);
    req_o.valid = 1'h0;
    bank_wr_o = 1'h1;
    bank_wdata_o = b;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
endmodule

// ===== testbench/test_mbd_decoder.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module test_mbd_decoder;
  typedef struct packed {
    logic [1:0] var_sel;
    logic [2:0] bank;
    logic dir;
    logic [15:0] addr;
    logic [15:0] phys;
    logic [7:0] sel;
  } mbd_row_t;

  localparam int N_ROWS = 36;
  // sel order: io ext_io ram gpr flash nvw vector prohib
  mbd_row_t rows [N_ROWS] = '{
    {2'h2,3'h0,1'h0,16'h0000,16'h0000,8'h80}, {2'h2,3'h0,1'h0,16'h007F,16'h007F,8'h80},
    {2'h2,3'h0,1'h0,16'h0080,16'h0080,8'h01}, {2'h2,3'h0,1'h0,16'h008F,16'h008F,8'h01},
    {2'h2,3'h0,1'h0,16'h0090,16'h0090,8'h20}, {2'h2,3'h0,1'h0,16'h0100,16'h0100,8'h30},
    {2'h2,3'h0,1'h0,16'h01FF,16'h01FF,8'h30}, {2'h2,3'h0,1'h0,16'h0200,16'h0200,8'h20},
    {2'h2,3'h0,1'h0,16'h048F,16'h048F,8'h20}, {2'h2,3'h0,1'h0,16'h0490,16'h0490,8'h01},
    {2'h2,3'h0,1'h0,16'h0F80,16'h0F80,8'h40}, {2'h2,3'h0,1'h0,16'h0FFF,16'h0FFF,8'h40},
    {2'h2,3'h0,1'h0,16'hEFFF,16'hEFFF,8'h01}, {2'h2,3'h0,1'h0,16'hF000,16'hF000,8'h08},
    {2'h2,3'h0,1'h0,16'hFFBA,16'hFFBA,8'h08}, {2'h2,3'h0,1'h0,16'hFFBB,16'hFFBB,8'h0C},
    {2'h2,3'h0,1'h0,16'hFFBF,16'hFFBF,8'h0C}, {2'h2,3'h0,1'h0,16'hFFC0,16'hFFC0,8'h0A},
    {2'h2,3'h0,1'h0,16'hFFFF,16'hFFFF,8'h0A}, {2'h2,3'h0,1'h1,16'h0005,16'h0005,8'h80},
    {2'h2,3'h0,1'h1,16'h0F80,16'h0080,8'h01}, {2'h2,3'h0,1'h1,16'hFF90,16'h0090,8'h20},
    {2'h2,3'h1,1'h1,16'h0080,16'h0100,8'h30}, {2'h2,3'h1,1'h1,16'h007F,16'h007F,8'h80},
    {2'h2,3'h7,1'h1,16'h00FF,16'h047F,8'h20}, {2'h2,3'h4,1'h1,16'h008F,16'h028F,8'h20},
    {2'h1,3'h4,1'h1,16'h008F,16'h028F,8'h20}, {2'h1,3'h4,1'h1,16'h0090,16'h0290,8'h01},
    {2'h1,3'h0,1'h0,16'h0290,16'h0290,8'h01}, {2'h1,3'h0,1'h0,16'h01FF,16'h01FF,8'h30},
    {2'h0,3'h0,1'h0,16'h018F,16'h018F,8'h30}, {2'h0,3'h0,1'h0,16'h0190,16'h0190,8'h01},
    {2'h0,3'h2,1'h1,16'h008F,16'h018F,8'h30}, {2'h0,3'h2,1'h1,16'h0090,16'h0190,8'h01},
    {2'h0,3'h3,1'h1,16'h0085,16'h0205,8'h01}, {2'h3,3'h0,1'h0,16'h048F,16'h048F,8'h20}
  };

  logic ref_clk_i = 1'h0;
  logic rst_b_i = 1'h0;
  logic [1:0] variant_i = 2'h2;
  mbd_pkg::mbd_req_t req;
  logic bank_wr;
  logic [2:0] bank_wdata;
  logic rsp_valid;
  mbd_pkg::mbd_sel_t sel;
  logic [15:0] phys;
  logic [7:0] rdata;
  logic [2:0] bank_ptr;
  logic [2:0] cur_bank = 3'h0;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  mbd_cpu_model cpu (.clk_i(ref_clk_i), .req_o(req), .bank_wr_o(bank_wr), .bank_wdata_o(bank_wdata));

  mbd_decoder uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .variant_i(variant_i), .req_i(req),
    .bank_wr_i(bank_wr), .bank_wdata_i(bank_wdata), .rsp_valid_o(rsp_valid), .sel_o(sel),
    .phys_addr_o(phys), .rdata_o(rdata), .bank_ptr_o(bank_ptr));

  // ------------
  // checking and verdict
  // ------------
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_sel(input logic [7:0] exp);
    chk_val("sel_o", {8'h00, exp}, {8'h00, sel});
  endtask

  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run is about 80 cycles
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // ------------
  // main sequence
  // ------------
  initial
  begin
    repeat (10) @(negedge ref_clk_i);
    rst_b_i = 1'h1;
    repeat (4) @(negedge ref_clk_i);
    chk_val("bank_ptr_o", 16'h0000, 16'(bank_ptr));
    for (int i = 0; i < N_ROWS; i++)
    begin
      if (rows[i].var_sel != variant_i)
      begin
        variant_i = rows[i].var_sel;
        repeat (3) cpu.idle();
      end
      if (rows[i].bank != cur_bank)
      begin
        cur_bank = rows[i].bank;
        cpu.load_bank(cur_bank);
        chk_val("bank_ptr_o", 16'(cur_bank), 16'(bank_ptr));
      end
      cpu.issue(rows[i].dir, 1'h0, rows[i].addr, 8'h00);
      chk_val("rsp_valid_o", 16'h0001, 16'(rsp_valid));
      chk_val("phys_addr_o", rows[i].phys, phys);
      chk_sel(rows[i].sel);
      if (!rows[i].sel[5])
        chk_val("rdata_o", 16'h0000, 16'(rdata));
    end
    // banked write, then ordinary read of the same byte on the next cycle
    cpu.load_bank(3'h2);
    cpu.issue(1'h1, 1'h1, 16'h0085, 8'h5A);
    chk_val("phys_addr_o", 16'h0185, phys);
    cpu.issue(1'h0, 1'h0, 16'h0185, 8'h00);
    chk_sel(8'h30);
    chk_val("rdata_o", 16'h005A, 16'(rdata));
    // a write into the hole above ram must not alias onto ram
    cpu.issue(1'h0, 1'h1, 16'h0090, 8'h11);
    cpu.issue(1'h0, 1'h1, 16'h0490, 8'hEE);
    cpu.issue(1'h0, 1'h0, 16'h0090, 8'h00);
    chk_val("rdata_o", 16'h0011, 16'(rdata));
    cpu.issue(1'h0, 1'h0, 16'h0490, 8'h00);
    chk_sel(8'h01);
    chk_val("rdata_o", 16'h0000, 16'(rdata));
    cpu.idle();
    chk_val("rsp_valid_o", 16'h0000, 16'(rsp_valid));
    // second reset in mid-run
    rst_b_i = 1'h0;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk_val("bank_ptr_o", 16'h0000, 16'(bank_ptr));
    chk_sel(8'h00);
    // release again and make sure the block decodes afresh
    rst_b_i = 1'h1;
    repeat (4) @(negedge ref_clk_i);
    chk_val("bank_ptr_o", 16'h0000, 16'(bank_ptr));
    chk_val("rsp_valid_o", 16'h0000, 16'(rsp_valid));
    cpu.issue(1'h1, 1'h0, 16'h0005, 8'h00);
    chk_sel(8'h80);
    chk_val("phys_addr_o", 16'h0005, phys);
    cpu.idle();
    summarize();
  end
endmodule
